//--- rtl/sipo_latch.sv
// serial-in parallel-out shift register with storage register and three-state outputs
//
// What this block does
// - eight-stage shift register takes serial data each shift edge, moving bits onward
// - storage clock edge copies all eight shift stages into the storage register
// - storage register drives eight parallel outputs, each able to float
// - shift and storage registers have separate independent clocks
// - low clear zeroes every shift stage at once, overriding the clock
// - last shift stage appears on the cascade output for chaining
// - both clocks act on rising edges only; falling edges change nothing
// - with clocks tied, storage takes the shift contents from before that edge
// - clear is active low; controller raises it before shifting edges
`timescale 1ns/1ps
`include "sipo_defs.svh"
module sipo_latch #(
	parameter int WIDTH = `SIPO_WIDTH
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic shift_clock_i,
	input wire logic storage_clock_i,
	input wire logic serial_data_in_i,
	input wire logic shift_clear_n_i,
	input wire logic output_enable_n_i,
	output sipo_pkg::sipo_pins_type parallel_outputs_o,
	output logic cascade_out_o
);

	// ----------------------------------------
	// shift domain
	// ----------------------------------------
	sipo_pkg::sipo_word_type shift_q;
	sipo_pkg::sipo_word_type shift_d;

	always_comb begin
		shift_d = {shift_q[WIDTH-2:0], serial_data_in_i};
	end

	// clear is a true asynchronous override, not sampled, so it works with the clock stopped
	always_ff @(posedge shift_clock_i or negedge shift_clear_n_i) begin
		if (!shift_clear_n_i) begin
			shift_q <= `SIPO_SHIFT_RST;
		end else begin
			shift_q <= shift_d;
		end
	end

	assign cascade_out_o = shift_q[WIDTH-1];

	shift_in_a: assert property (@(posedge shift_clock_i) disable iff (!shift_clear_n_i)
		##1 shift_q[0] == $past(serial_data_in_i))
		else $error("shift stage 0 missed the serial bit");
	shift_move_a: assert property (@(posedge shift_clock_i) disable iff (!shift_clear_n_i)
		##1 shift_q[WIDTH-1:1] == $past(shift_q[WIDTH-2:0]))
		else $error("shift stages did not move onward");
	cascade_tap_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		cascade_out_o == shift_q[WIDTH-1])
		else $error("cascade output differs from last stage");
	clear_zero_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!shift_clear_n_i && $past(!shift_clear_n_i)) |-> shift_q == `SIPO_SHIFT_RST)
		else $error("shift register not zero under clear");

	// ----------------------------------------
	// storage domain
	// ----------------------------------------
	// no reset pin reaches this domain and its clock may stand still, hence power-up values
	sipo_pkg::sipo_word_type store_q = `SIPO_STORE_RST;
	sipo_pkg::sipo_word_type store_d;
	logic store_tgl_q = 1'b0;
	logic store_tgl_d;

	always_comb begin
		store_d = shift_q;
		store_tgl_d = !store_tgl_q;
	end

	// tied clocks read shift_q before its update: one pulse behind
	always_ff @(posedge storage_clock_i) begin
		store_q <= store_d;
		store_tgl_q <= store_tgl_d;
	end

	latch_copy_a: assert property (@(posedge storage_clock_i) disable iff (!rst_b_i)
		##1 store_q == $past(shift_q))
		else $error("storage did not copy the shift register");
	store_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(storage_clock_i == $past(storage_clock_i)) |-> $stable(store_q))
		else $error("storage changed without a storage edge");

	// ----------------------------------------
	// system domain: pin drivers
	// ----------------------------------------
	// toggle carries the latch event; the word itself is stable for a storage period
	logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
	logic oe_s1_q, oe_s2_q;
	logic tgl_s1_d, tgl_s2_d, tgl_s3_d;
	logic oe_s1_d, oe_s2_d;
	sipo_pkg::sipo_pins_type pins_q;
	sipo_pkg::sipo_pins_type pins_d;
	// per-pin enables built apart so pins_d keeps a single driving process
	sipo_pkg::sipo_word_type oe_d;

	always_comb begin
		tgl_s1_d = store_tgl_q;
		tgl_s2_d = tgl_s1_q;
		tgl_s3_d = tgl_s2_q;
		oe_s1_d = output_enable_n_i;
		oe_s2_d = oe_s1_q;
		pins_d = pins_q;
		pins_d.oe = oe_d;
		if (tgl_s2_q != tgl_s3_q) begin
			pins_d.data = store_q;
		end
		if (!rst_b_i) begin
			tgl_s1_d = 1'b0;
			tgl_s2_d = 1'b0;
			tgl_s3_d = 1'b0;
			oe_s1_d = 1'b1;
			oe_s2_d = 1'b1;
			pins_d.data = `SIPO_PIN_RST;
		end
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_oe
		always_comb begin
			oe_d[i] = rst_b_i && !oe_s2_q;
		end
	end

	always_ff @(posedge clk_i) begin
		tgl_s1_q <= tgl_s1_d;
		tgl_s2_q <= tgl_s2_d;
		tgl_s3_q <= tgl_s3_d;
		oe_s1_q <= oe_s1_d;
		oe_s2_q <= oe_s2_d;
		pins_q <= pins_d;
	end

	assign parallel_outputs_o = pins_q;

	sequence latch_seen_s;
		tgl_s2_q != tgl_s3_q;
	endsequence
	sequence word_out_s;
		##1 parallel_outputs_o.data == $past(store_q);
	endsequence
	pin_capture_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		latch_seen_s |-> word_out_s)
		else $error("parallel outputs missed a stored word");
	pin_float_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		oe_s2_q |=> parallel_outputs_o.oe == `SIPO_OE_OFF)
		else $error("outputs drive while disabled");
	pin_drive_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(!oe_s2_q && $past(rst_b_i)) |=> parallel_outputs_o.oe == `SIPO_OE_ON)
		else $error("outputs float while enabled");

endmodule

//--- rtl/sipo_defs.svh
// constants for the serial-in parallel-out latch
`ifndef SIPO_DEFS_SVH
`define SIPO_DEFS_SVH
`define SIPO_WIDTH 8
`define SIPO_SHIFT_RST 8'h00
`define SIPO_STORE_RST 8'h00
`define SIPO_PIN_RST 8'h00
`define SIPO_OE_OFF 8'h00
`define SIPO_OE_ON 8'hff
`endif

//--- rtl/sipo_pkg.sv
// types for the serial-in parallel-out latch
`include "sipo_defs.svh"
package sipo_pkg;
	typedef logic [`SIPO_WIDTH-1:0] sipo_word_type;
	typedef struct packed {
		sipo_word_type data;
		sipo_word_type oe;
	} sipo_pins_type;
endpackage

//--- tb/sipo_host.sv
// host model driving the serial link
`timescale 1ns/1ps
module sipo_host (
	output logic shift_clock_o,
	output logic storage_clock_o,
	output logic serial_data_o,
	output logic shift_clear_n_o
);
	initial begin
		{shift_clock_o, storage_clock_o, serial_data_o, shift_clear_n_o} = 4'h1;
	end
	// msb first; link clock stands still between words
	task automatic send(input logic [7:0] w, input logic tie);
		for (int i = 7; i >= 0; i--) begin
			serial_data_o <= w[i];
			#40 shift_clock_o <= 1'b1;
			storage_clock_o <= tie;
			#40 shift_clock_o <= 1'b0;
			storage_clock_o <= 1'b0;
		end
		serial_data_o <= ~w[0];
	endtask
	task automatic latch();
		#40 storage_clock_o <= 1'b1;
		#40 storage_clock_o <= 1'b0;
	endtask
	// clear raised well before the next shift edge
	task automatic clear();
		#40 shift_clear_n_o <= 1'b0;
		#40 shift_clear_n_o <= 1'b1;
		#40;
	endtask
endmodule

//--- tb/sipo_latch_tb.sv
// self-checking bench for the serial-in parallel-out latch
`timescale 1ns/1ps
module sipo_latch_tb;
	typedef struct {logic [7:0] w; logic [7:0] q; logic c;} sipo_row_type;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic oe_n = 1'b0;
	logic sck, rck, sdi, clr_n, cas;
	sipo_pkg::sipo_pins_type pins;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;
	sipo_row_type rows [4] = '{'{8'h00, 8'h00, 1'b0}, '{8'h3c, 8'h3c, 1'b0},
		'{8'hff, 8'hff, 1'b1}, '{8'ha5, 8'ha5, 1'b1}};
	sipo_host host (.shift_clock_o(sck), .storage_clock_o(rck), .serial_data_o(sdi),
		.shift_clear_n_o(clr_n));
	sipo_latch dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .shift_clock_i(sck),
		.storage_clock_i(rck), .serial_data_in_i(sdi), .shift_clear_n_i(clr_n),
		.output_enable_n_i(oe_n), .parallel_outputs_o(pins), .cascade_out_o(cas));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (failures == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ceiling far above the under nine hundred cycles the run needs
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			results();
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		#1 check(pins.oe, 8'h00);
		@(posedge clk_i) rst_b_i <= 1'b1;
		#1;
		foreach (rows[i]) begin
			host.send(rows[i].w, 1'b0);
			check(8'(cas), 8'(rows[i].c));
			host.latch();
			check(pins.data, rows[i].q);
			check(pins.oe, 8'hff);
		end
		host.clear();
		check(8'(cas), 8'h00);
		check(pins.data, 8'ha5);
		host.latch();
		check(pins.data, 8'h00);
		@(posedge clk_i) oe_n <= 1'b1;
		repeat (4) @(posedge clk_i);
		#1 check(pins.oe, 8'h00);
		host.send(8'hff, 1'b0);
		check(8'(cas), 8'h01);
		host.send(8'h96, 1'b1);
		check(pins.data, 8'hcb);
		@(posedge clk_i) oe_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		#1 check(pins.oe, 8'hff);
		results();
	end
endmodule
